// >>> rtl/mdsfr_pkg.sv
`default_nettype none
package mdsfr_pkg;
  // Frame shape
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 4;
  localparam int FAULT_W = 11;
  localparam int STAT_W = 12;
  localparam int DATA_W = 13;

  // Command word fields
  localparam int CMD_WR_BIT = 15;
  localparam int CMD_ADDR_HI = 14;
  localparam int CMD_ADDR_LO = 13;
  localparam int STAT_FRM_BIT = 11;

  // Register selection codes
  localparam logic [1:0] ADDR_IDENT = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_CONFIG = 2'h3;

  // Reset values of the stored register data
  localparam logic [DATA_W-1:0] MASK_RST = 13'h06F1;
  localparam logic [DATA_W-1:0] CONFIG_RST = 13'h0D98;
  localparam logic [STAT_W-1:0] STATUS_RST = 12'h000;

  // Synchroniser order: wake, inhibit, mosi, sclk, cs_n
  localparam int SYNC_N = 5;
  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h01;
  localparam int SY_CS = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_INH = 3;
  localparam int SY_WAKE = 4;

  // Timing
  localparam int REF_CLK_HZ = 200_000_000;
  localparam int SCLK_MAX_HZ = 10_000_000;
  localparam int CS_GAP_NS = 300;
  localparam int HALF_CYC_I = (REF_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int GAP_CYC_I = (CS_GAP_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] SCLK_HALF_CYC = HALF_CYC_I[7:0];
  localparam logic [7:0] CS_GAP_CYC = GAP_CYC_I[7:0];

  // Host command port offsets
  localparam logic [1:0] HOST_TX_OFF = 2'h0;
  localparam logic [1:0] HOST_RX_OFF = 2'h1;
  localparam logic [1:0] HOST_STAT_OFF = 2'h2;

  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_HIGH, H_LOW, H_LAG, H_GAP
  } mdsfr_hstate_t;
endpackage : mdsfr_pkg
`default_nettype wire

// >>> rtl/mdsfr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mdsfr_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_drv;
  logic miso_oe_n;
  logic miso;

  // Released line floats high through a pull-up
  assign miso = miso_oe_n ? 1'b1 : miso_drv;

  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev (input sclk, input cs_n, input mosi, output miso_drv, output miso_oe_n);
endinterface : mdsfr_if
`default_nettype wire

// >>> rtl/mdsfr_host.sv
`timescale 1ns/100ps
`default_nettype none
module mdsfr_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  mdsfr_if.host link
);
  import mdsfr_pkg::*;

  mdsfr_hstate_t state_q;
  logic [7:0] tmr_q;
  logic [4:0] bits_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [15:0] rx_last_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic tmr_done;
  logic start;

  assign tmr_done = (tmr_q == 8'h00);
  // A start while busy is dropped; software polls busy first
  assign start = cmd_wr && (cmd_addr == HOST_TX_OFF) && (state_q == H_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and half-period timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      tmr_q <= 8'h00;
      bits_q <= 5'h00;
    end else begin
      if (!tmr_done) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        H_IDLE: begin
          if (start) begin
            state_q <= H_LEAD;
            tmr_q <= SCLK_HALF_CYC - 8'h01;
            bits_q <= 5'h00;
          end
        end
        H_LEAD: begin
          if (tmr_done) begin
            state_q <= H_HIGH;
            tmr_q <= SCLK_HALF_CYC - 8'h01;
          end
        end
        H_HIGH: begin
          if (tmr_done) begin
            state_q <= H_LOW;
            tmr_q <= SCLK_HALF_CYC - 8'h01;
            bits_q <= bits_q + 5'h01;
          end
        end
        H_LOW: begin
          if (tmr_done) begin
            state_q <= (bits_q == 5'(FRAME_BITS)) ? H_LAG : H_HIGH;
            tmr_q <= SCLK_HALF_CYC - 8'h01;
          end
        end
        H_LAG: begin
          if (tmr_done) begin
            state_q <= H_GAP;
            tmr_q <= CS_GAP_CYC - 8'h01;
          end
        end
        H_GAP: begin
          if (tmr_done) begin
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins: MOSI moves on the rising edge, MISO taken on the falling one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      rx_last_q <= 16'h0000;
    end else begin
      if (start) begin
        cs_n_q <= 1'b0;
        tx_q <= cmd_wdata;
      end
      if (tmr_done && (state_q == H_LEAD || (state_q == H_LOW && bits_q != 5'(FRAME_BITS)))) begin
        sclk_q <= 1'b1;
        mosi_q <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end
      if (tmr_done && state_q == H_HIGH) begin
        sclk_q <= 1'b0;
        rx_q <= {rx_q[14:0], link.miso};
      end
      if (tmr_done && state_q == H_LAG) begin
        cs_n_q <= 1'b1;
        rx_last_q <= rx_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= 16'h0000;
    end else if (cmd_rd) begin
      case (cmd_addr)
        HOST_RX_OFF: cmd_rdata <= rx_last_q;
        HOST_STAT_OFF: cmd_rdata <= {15'h0000, state_q != H_IDLE};
        default: cmd_rdata <= 16'h0000;
      endcase
    end else begin
      cmd_rdata <= 16'h0000;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
endmodule : mdsfr_host
`default_nettype wire

// >>> rtl/mdsfr_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Frame is sixteen bits, MSB first, chip select low
// - Sample MOSI on falling, move MISO on rising
// - Slave only, fixed mode, clock at most 10 MHz
// - Bits beyond sixteen pass on to MISO
// - Zero or non-multiple-of-16 count: discard, flag error
// - Write to register zero is a framing error
// - Reply is previously selected register, taken at select
// - First frame after wake returns fault status
// - Bit 15 write; read ignores data bits
// - Bits 14:13 pick the target register
// - Identification: zeros, one id bit, revision bits
// - Upper status bit layout, framing error at 11
// - No fault means status bits read zero
// - Fault latches until cleared after it ends
// - Inhibit falling edge clears inactive faults
// - Wake rising edge clears inactive faults
// - Writing one clears an inactive fault bit
// - MISO driven only while chip select is low
// - Master keeps select high 300 ns between frames
// - Master verifies writes by reading them back
// - Lower status bit layout down to overheat
// - Mask gates matching faults onto the fault pin
module mdsfr_dev #(
  parameter logic DEV_ID_BIT = 1'b0,
  parameter logic [3:0] REV_BITS = 4'h0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  mdsfr_if.dev link,
  input wire logic output_inhibit_pin,
  input wire logic wake_enable_pin,
  input wire logic [mdsfr_pkg::FAULT_W-1:0] fault_active,
  output logic fault_flag_n_pin,
  output logic [mdsfr_pkg::DATA_W-1:0] mask_bits,
  output logic [mdsfr_pkg::DATA_W-1:0] config_bits
);
  import mdsfr_pkg::*;

  // DEV_ID_BIT and REV_BITS defaults are arbitrary values

  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] f_q;
  logic [SYNC_N-1:0] fp_q;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic inh_fall;
  logic wake_rise;
  logic [15:0] sr_q;
  logic [CNT_W-1:0] cnt_q;
  logic seen_q;
  logic miso_q;
  logic miso_oe_n_q;
  logic [1:0] sel_q;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] config_q;
  logic ff_n_q;
  logic [15:0] tx_word;
  logic [1:0] cmd_addr;
  logic cmd_wr;
  logic frm_err;
  logic commit;
  logic [STAT_W-1:0] clr_req;
  logic [STAT_W-1:0] set_req;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a level counts once stages two and three agree
  assign raw = {wake_enable_pin, output_inhibit_pin, link.mosi, link.sclk, link.cs_n};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      fp_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fp_q <= f_q;
    end
  end

  // Filtered copies, one per pin
  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_flt
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          f_q[i] <= SYNC_RST[i];
        end else if (s2_q[i] == s3_q[i]) begin
          f_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  // Edge strobes, one ref_clk cycle each
  assign cs_low = !f_q[SY_CS];
  assign cs_fall = !f_q[SY_CS] && fp_q[SY_CS];
  assign cs_rise = f_q[SY_CS] && !fp_q[SY_CS];
  assign sclk_rise = f_q[SY_SCLK] && !fp_q[SY_SCLK];
  assign sclk_fall = !f_q[SY_SCLK] && fp_q[SY_SCLK];
  assign inh_fall = !f_q[SY_INH] && fp_q[SY_INH];
  assign wake_rise = f_q[SY_WAKE] && !fp_q[SY_WAKE];

  ////////////////////////////////////////////////////////////////////////
  // Reply word for the register picked by the previous command
  always_comb begin
    case (sel_q)
      ADDR_IDENT: tx_word = {11'h000, DEV_ID_BIT, REV_BITS};
      ADDR_STATUS: tx_word = {1'b0, ADDR_STATUS, 1'b0, stat_q};
      ADDR_MASK: tx_word = {1'b0, ADDR_MASK, mask_q};
      ADDR_CONFIG: tx_word = {1'b0, ADDR_CONFIG, config_q};
      default: tx_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register: the reply leaves the top while MOSI enters the bottom,
  // so after sixteen clocks the received bits emerge for the next device
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= 16'h0000;
      miso_q <= 1'b0;
    end else if (cs_fall) begin
      sr_q <= tx_word;
      miso_q <= tx_word[15];
    end else if (cs_low) begin
      if (sclk_rise) begin
        miso_q <= sr_q[15];
      end
      if (sclk_fall) begin
        sr_q <= {sr_q[14:0], f_q[SY_MOSI]};
      end
    end
  end

  // Clock count modulo sixteen plus a flag for any clock at all
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
    end else if (cs_fall) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
    end else if (cs_low && sclk_fall) begin
      cnt_q <= cnt_q + 4'h1;
      seen_q <= 1'b1;
    end
  end

  // MISO released while select is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_oe_n_q <= 1'b1;
    end else begin
      miso_oe_n_q <= !cs_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame check at select release; the last sixteen bits are the command
  assign cmd_addr = sr_q[CMD_ADDR_HI:CMD_ADDR_LO];
  assign cmd_wr = sr_q[CMD_WR_BIT];
  assign frm_err = !seen_q || (cnt_q != '0) || (cmd_wr && cmd_addr == ADDR_IDENT);
  assign commit = cs_rise && !frm_err;

  // Register selection for the next reply; a bad frame keeps the old one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= ADDR_STATUS;
    end else if (wake_rise) begin
      sel_q <= ADDR_STATUS;
    end else if (commit) begin
      sel_q <= cmd_addr;
    end
  end

  // Mask and configuration writes; reads leave the data bits unused
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
      config_q <= CONFIG_RST;
    end else if (commit && cmd_wr) begin
      if (cmd_addr == ADDR_MASK) begin
        mask_q <= sr_q[DATA_W-1:0];
      end
      if (cmd_addr == ADDR_CONFIG) begin
        config_q <= sr_q[DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched faults. A clear only touches bits whose cause has gone, and a
  // set in the same cycle wins, so no event is ever lost.
  always_comb begin
    clr_req = '0;
    if (inh_fall || wake_rise) begin
      clr_req = '1;
    end else if (commit && cmd_wr && cmd_addr == ADDR_STATUS) begin
      clr_req = sr_q[STAT_W-1:0];
    end
    clr_req = clr_req & ~{1'b0, fault_active};
    set_req = {cs_rise && frm_err, fault_active};
    stat_d = (stat_q & ~clr_req) | set_req;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= STATUS_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Fault pin low while any unmasked latched fault is present
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_n_q <= 1'b1;
    end else begin
      ff_n_q <= !(|(stat_q & mask_q[STAT_W-1:0]));
    end
  end

  assign link.miso_drv = miso_q;
  assign link.miso_oe_n = miso_oe_n_q;
  assign fault_flag_n_pin = ff_n_q;
  assign mask_bits = mask_q;
  assign config_bits = config_q;
endmodule : mdsfr_dev
`default_nettype wire

// >>> bench/mdsfr_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mdsfr_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe_n
);
  logic [7:0] gap_q;
  logic [4:0] rise_q;
  logic [3:0] age_q;
  logic [7:0] run_q;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Select-high time, saturating so a long idle never wraps to a short gap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 8'hFF;
    else if (!cs_n) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  // Serial clock rises seen in the current frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rise_q <= 5'h00;
    else if ($fell(cs_n)) rise_q <= 5'h00;
    else if ($rose(sclk)) rise_q <= rise_q + 5'h01;
  end
  // Cycles since the last event that may move the reply line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) age_q <= 4'hF;
    else if ($rose(sclk) || $changed(cs_n)) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  // Cycles the serial clock has held its level; a counter instead of a long
  // repetition keeps the property cheap for the tools
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run_q <= 8'hFF;
    else if ($changed(sclk)) run_q <= 8'h01;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  // Line released and staying released
  sequence released;
    miso_oe_n [*4];
  endsequence
  a_lead_time: assert property ($fell(cs_n) |-> !sclk [*6])
    else $error("serial clock rose too soon after select");
  a_sclk_high: assert property ($fell(sclk) |-> run_q >= 8'h09)
    else $error("serial clock high phase too short");
  a_sclk_low: assert property ($rose(sclk) |-> run_q >= 8'h09)
    else $error("serial clock low phase too short");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_frame_len: assert property ($rose(cs_n) |-> rise_q == 5'd16)
    else $error("frame did not carry sixteen clocks");
  a_select_gap: assert property ($fell(cs_n) |-> gap_q >= 8'd60)
    else $error("select gap shorter than allowed");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_on: assert property ($fell(cs_n) |-> ##[1:8] !miso_oe_n)
    else $error("reply line not driven after select");
  a_miso_off: assert property ($rose(cs_n) |-> ##[1:8] released)
    else $error("reply line not released after deselect");
  a_idle_quiet: assert property (cs_n [*8] |-> miso_oe_n)
    else $error("reply line driven while deselected");
  a_miso_moves: assert property (!miso_oe_n && $changed(miso_drv) |-> age_q <= 4'd8)
    else $error("reply bit moved away from a clock rise");
endmodule : mdsfr_sva
`default_nettype wire

// >>> bench/motor_driver_spi_fault_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module motor_driver_spi_fault_regs_bench;
  import mdsfr_pkg::*;
  localparam logic ID_BIT = 1'b0; // Arbitrary identifier value
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision value
  logic ref_clk;
  logic rst_n;
  logic [1:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic cmd_wr;
  logic cmd_rd;
  logic [15:0] cmd_rdata;
  logic inhibit;
  logic wake;
  logic [FAULT_W-1:0] fault_active;
  logic fault_flag_n;
  logic [DATA_W-1:0] mask_bits;
  logic [DATA_W-1:0] config_bits;
  logic [DATA_W-1:0] mask_m;
  logic [DATA_W-1:0] cfg_m;
  logic [STAT_W-1:0] stat_m;
  logic [1:0] sel_m;
  int n_errors;
  int samples_checked;
  int i;
  mdsfr_if mdsfr_if_i ();
  mdsfr_host mdsfr_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .link(mdsfr_if_i.host));
  mdsfr_dev #(.DEV_ID_BIT(ID_BIT), .REV_BITS(REV)) mdsfr_dev_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(mdsfr_if_i.dev), .output_inhibit_pin(inhibit), .wake_enable_pin(wake), .fault_active(fault_active),
    .fault_flag_n_pin(fault_flag_n), .mask_bits(mask_bits), .config_bits(config_bits));
  mdsfr_sva mdsfr_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(mdsfr_if_i.sclk), .cs_n(mdsfr_if_i.cs_n),
    .mosi(mdsfr_if_i.mosi), .miso_drv(mdsfr_if_i.miso_drv), .miso_oe_n(mdsfr_if_i.miso_oe_n));
  ////////////////////////////////////////////////////////////
  // Free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Expected reply: the register selected before this frame
  function automatic logic [15:0] reply();
    case (sel_m)
      ADDR_IDENT: return {11'h000, ID_BIT, REV};
      ADDR_STATUS: return {4'h2, stat_m};
      ADDR_MASK: return {3'h2, mask_m};
      default: return {3'h3, cfg_m};
    endcase
  endfunction : reply
  task automatic pins();
    chk({3'h0, mask_bits}, {3'h0, mask_m}, "mask");
    chk({3'h0, config_bits}, {3'h0, cfg_m}, "config");
    chk({15'h0, fault_flag_n}, {15'h0, ~|(stat_m & mask_m[11:0])}, "flag");
    chk({15'h0, mdsfr_if_i.miso}, 16'h0001, "idle line");
  endtask : pins
  // Host port cycles, one strobe at a time, read data taken in the following cycle
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
    @(posedge ref_clk);
  endtask : rd
  // One full frame, compared against the model, which is then advanced
  task automatic xfer(input logic [15:0] w, input string what);
    logic [15:0] d;
    int k;
    cmd_addr <= HOST_TX_OFF;
    cmd_wdata <= w;
    cmd_wr <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    @(posedge ref_clk);
    d = 16'h0001;
    for (k = 0; k < 3000 && d[0] !== 1'b0; k++) rd(HOST_STAT_OFF, d);
    chk({15'h0, d[0]}, 16'h0000, "busy");
    rd(HOST_RX_OFF, d);
    chk(d, reply(), what);
    if (w[15] && w[14:13] == ADDR_IDENT) stat_m[STAT_FRM_BIT] = 1'b1;
    else begin
      sel_m = w[14:13];
      if (w[15] && sel_m == ADDR_STATUS) stat_m = stat_m & ~(w[11:0] & ~{1'b0, fault_active});
      if (w[15] && sel_m == ADDR_MASK) mask_m = w[12:0];
      if (w[15] && sel_m == ADDR_CONFIG) cfg_m = w[12:0];
    end
    pins();
  endtask : xfer
  task automatic set_fault(input logic [FAULT_W-1:0] v);
    fault_active <= v;
    repeat (8) @(posedge ref_clk);
    stat_m = stat_m | {1'b0, v};
  endtask : set_fault
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmd_addr = 2'h0;
    cmd_wdata = 16'h0000;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    inhibit = 1'b0;
    wake = 1'b1;
    fault_active = '0;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(32'h83A1));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    mask_m = MASK_RST;
    cfg_m = CONFIG_RST;
    stat_m = STATUS_RST;
    sel_m = ADDR_STATUS;
    pins();
    for (i = 0; i < 5; i++) xfer({1'b0, 2'(i + 2), 13'($urandom)}, "read");
    for (i = 0; i < 8; i++) xfer({1'b1, i[0] ? ADDR_CONFIG : ADDR_MASK, 13'($urandom)}, "write");
    xfer({3'h4, 13'($urandom)}, "write ident");
    xfer(16'h2000, "after refused");
    xfer(16'h2000, "frame flag");
    // Latch faults, try to clear while present, then clear by write, inhibit and wake.
    // Pin pulses last a full microsecond so the clear would hold on a real part too.
    for (i = 0; i < 3; i++) begin
      set_fault(11'($urandom_range(1, 2047)));
      xfer(16'hC000 | 16'($urandom_range(0, 4095)), "mask");
      xfer(16'hAFFF, "clear held");
      set_fault('0);
      if (i == 0) xfer(16'hA000 | 16'($urandom_range(0, 4095)), "clear write");
      if (i == 1) begin
        inhibit <= 1'b1;
        repeat (200) @(posedge ref_clk);
        inhibit <= 1'b0;
        repeat (20) @(posedge ref_clk);
        stat_m = '0;
      end
      if (i == 2) begin
        wake <= 1'b0;
        repeat (200) @(posedge ref_clk);
        wake <= 1'b1;
        repeat (20) @(posedge ref_clk);
        stat_m = '0;
        sel_m = ADDR_STATUS;
      end
      xfer(16'h4000, "after clear");
      xfer(16'h2000, "status");
    end
    wrap_up();
  end
  // Watchdog well beyond the expected run of about 12k cycles, at 50k cycles
  initial begin
    #250000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : motor_driver_spi_fault_regs_bench
`default_nettype wire
